// ### sbi_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sbi_buf2 #(
	parameter int WIDTH = 8
)(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);

	logic [WIDTH-1:0] mem_r [2];
	logic [WIDTH-1:0] mem_nxt [2];
	logic rd_ptr_r, rd_ptr_nxt;
	logic wr_ptr_r, wr_ptr_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	// full and empty come straight from the count
	assign o_in_ready = (cnt_r != 2'd2);
	assign o_out_valid = (cnt_r != 2'd0);
	assign o_out_data = mem_r[rd_ptr_r];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// next pointers, count and storage
	always_comb
	begin
		mem_nxt = mem_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt = cnt_r;
		if (push)
		begin
			mem_nxt[wr_ptr_r] = i_in_data;
			wr_ptr_nxt = ~wr_ptr_r;
		end
		if (pop)
			rd_ptr_nxt = ~rd_ptr_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'd1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'd1;
	end

	// register stage
	always_ff @(posedge i_mclk)
	begin
		mem_r <= mem_nxt;
		if (i_srst)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'd0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// ### sbi_bus_model.sv
// remote bus master driving both lines open drain
`timescale 1ns/1ps
module sbi_bus_model (
	// resolved line levels
	input wire logic i_sda,
	input wire logic i_scl,
	// 1 = released, pull-up wins
	output logic o_sda_rel,
	output logic o_scl_rel,
	output int o_lost
);
	// clock stands high between frames
	initial
	begin
		o_sda_rel = 1'b1;
		o_scl_rel = 1'b1;
		o_lost = 0;
	end
	// let the clock go; a stretching device is waited for, but not forever
	task automatic clk_up();
		int n;
		n = 0;
		o_scl_rel = 1'b1;
		while (!i_scl && n < 4000)
		begin
			#25;
			n++;
		end
		if (!i_scl)
			o_lost++;
	endtask
	task automatic pulse();
		o_scl_rel = 1'b0;
		#100;
		clk_up();
		#100;
	endtask
	task automatic put_bit(input logic b);
		o_sda_rel = b;
		#50;
		clk_up();
		#100;
		o_scl_rel = 1'b0;
		#50;
	endtask
	task automatic start();
		o_sda_rel = 1'b0;
		#100;
		o_scl_rel = 1'b0;
		#50;
	endtask
	// msb first, ninth clock left to the receiver's acknowledge
	task automatic send(input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		put_bit(1'b1);
	endtask
	task automatic stop();
		o_sda_rel = 1'b0;
		#50;
		clk_up();
		#50;
		o_sda_rel = 1'b1;
		#100;
	endtask
endmodule

// ### sbi_checker.sv
// port checker for the serial register block
`timescale 1ns/1ps
module sbi_checker
	import sbi_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// register port
	input wire logic i_byte_select,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic [7:0] o_sfr_rdata,
	// lines
	input wire logic i_sda_in,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic i_scl_in,
	input wire logic o_scl_out,
	input wire logic o_scl_oe_n
);
	logic en_r;
	logic en_nxt;
	logic lc_wr;
	logic lc_rd;
	// shadow of the enable bit, so release checks know when the block is off
	always_comb
	begin
		lc_wr = i_sfr_wr && !i_byte_select && i_sfr_addr == SBI_ADDR_LINE_CONTROL;
		lc_rd = i_sfr_rd && i_sfr_addr == SBI_ADDR_LINE_CONTROL;
		en_nxt = lc_wr ? i_sfr_wdata[SBI_LC_ENABLE_POS] : en_r;
	end
	always_ff @(posedge i_mclk)
	begin
		en_r <= i_srst ? SBI_ENABLE_RST : en_nxt;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// enabling write of the line control register
	sequence s_lc_on;
		lc_wr && i_sfr_wdata[SBI_LC_ENABLE_POS];
	endsequence
	// bit data write while the lines are live
	sequence s_bd_wr;
		i_sfr_wr && !i_byte_select && i_sfr_addr == SBI_ADDR_BIT_DATA && en_r;
	endsequence
	chk_sda_low_only: assert property (o_sda_out == 1'b0)
		else $error("data line driven high");
	chk_scl_low_only: assert property (o_scl_out == 1'b0)
		else $error("clock line driven high");
	chk_off_release: assert property (!en_r [*2] |-> o_sda_oe_n && o_scl_oe_n)
		else $error("line pulled while disabled");
	chk_sda_follow: assert property (s_lc_on |-> ##2 o_sda_oe_n == $past(i_sfr_wdata[SBI_LC_DATA_POS], 2))
		else $error("data line does not follow control write");
	chk_scl_follow: assert property (s_lc_on ##0 !i_sfr_wdata[SBI_LC_STRETCH_POS]
		|-> ##2 o_scl_oe_n == $past(i_sfr_wdata[SBI_LC_CLOCK_POS], 2))
		else $error("clock line does not follow control write");
	chk_bit_drive: assert property (s_bd_wr |-> ##2 o_sda_oe_n == $past(i_sfr_wdata[SBI_BIT_DATA_POS], 2))
		else $error("data line does not follow bit write");
	chk_other_set: assert property (lc_rd && i_byte_select |=> o_sfr_rdata == 8'h00)
		else $error("bit set visible in byte mode");
	chk_status_width: assert property (i_sfr_rd && i_byte_select && i_sfr_addr == SBI_ADDR_BYTE_STATUS
		|=> o_sfr_rdata[7:5] == 3'h0)
		else $error("status wider than five bits");
	chk_off_levels: assert property (lc_rd && !i_byte_select && !en_r |=> o_sfr_rdata[7:6] == 2'h3)
		else $error("disabled lines not read high");
endmodule
bind sbi_serial_regs sbi_checker u_chk (.i_mclk, .i_srst, .i_byte_select, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
	.i_sfr_wdata, .o_sfr_rdata, .i_sda_in, .o_sda_out, .o_sda_oe_n, .i_scl_in, .o_scl_out, .o_scl_oe_n);

// ### sbi_pkg.sv
// package of addresses, field positions, reset values and codes for the serial bit/byte interface
package sbi_pkg;

	// ****************************************
	// register addresses on the core's register port
	// ****************************************
	localparam logic [7:0] SBI_ADDR_BYTE_DATA = 8'hD9;
	localparam logic [7:0] SBI_ADDR_BYTE_STATUS = 8'hD8;
	localparam logic [7:0] SBI_ADDR_BIT_DATA = 8'hD9;
	localparam logic [7:0] SBI_ADDR_BIT_INTERRUPT = 8'hD8;
	localparam logic [7:0] SBI_ADDR_LINE_CONTROL = 8'hDC;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SBI_BIT_DATA_POS = 0;
	localparam int SBI_INT_FLAG_POS = 0;
	localparam int SBI_LC_DATA_POS = 7;
	localparam int SBI_LC_CLOCK_POS = 6;
	localparam int SBI_LC_RISE_POS = 5;
	localparam int SBI_LC_BUSY_POS = 4;
	localparam int SBI_LC_RDONE_POS = 3;
	localparam int SBI_LC_WDONE_POS = 2;
	localparam int SBI_LC_STRETCH_POS = 1;
	localparam int SBI_LC_ENABLE_POS = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] SBI_BYTE_DATA_RST = 8'h00;
	localparam logic SBI_LINE_OUT_RST = 1'b1;
	localparam logic SBI_STRETCH_RST = 1'b0;
	localparam logic SBI_ENABLE_RST = 1'b0;
	localparam logic [3:0] SBI_BITCNT_RST = 4'h0;

	// ****************************************
	// byte-oriented status codes and bit counts
	// ****************************************
	localparam logic [4:0] SBI_STAT_IDLE = 5'h1F;
	localparam logic [4:0] SBI_STAT_BUSY = 5'h01;
	localparam logic [4:0] SBI_STAT_READY = 5'h02;
	localparam logic [4:0] SBI_STAT_STALL = 5'h03;
	localparam logic [3:0] SBI_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] SBI_BITS_WITH_ACK = 4'h9;

	// byte capture states, gray along idle -> shift -> push
	typedef enum logic [1:0]
	{
		SBI_ST_IDLE = 2'b00,
		SBI_ST_SHIFT = 2'b01,
		SBI_ST_PUSH = 2'b11
	} sbi_state_t;

endpackage

// ### sbi_serial_regs.sv
// register side of the two-wire serial interface, byte and bit register sets
`timescale 1ns/1ps

// Behaviour
// - select input picks byte or bit register set
// - byte set holds eight-bit serial data byte
// - five-bit status code, read only, writes ignored
// - bit data read returns received data bit
// - bit data write sets driven data bit
// - bit set holds interrupt flag register
// - line control read shows sampled data line
// - line control read shows sampled clock line
// - data output field drives data line low
// - clock output field drives clock line low
// - clock rise flag readable and writable
// - busy, read done, write done flags readable
// - stretch enable lets device hold clock low
// - lines driven and sampled only when enabled
module sbi_serial_regs (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// register set select from the core, 1 = byte set
	input wire logic i_byte_select,
	// core register port
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// data line, open drain
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// clock line, open drain
	input wire logic i_scl_in,
	output logic o_scl_out,
	output logic o_scl_oe_n
);
	import sbi_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [2:0] sda_sync_r, sda_sync_nxt;
	logic [2:0] scl_sync_r, scl_sync_nxt;
	logic sda_lvl_r, sda_lvl_nxt;
	logic scl_lvl_r, scl_lvl_nxt;
	logic sda_prev_r, scl_prev_r;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic wr_byte_data, rd_byte_data, wr_bit_data, rd_bit_data, wr_bit_int, wr_line_ctl;
	logic [7:0] byte_data_r, byte_data_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	sbi_state_t state_r, state_nxt;
	logic busy_r, busy_nxt;
	logic data_out_r, data_out_nxt;
	logic clock_out_r, clock_out_nxt;
	logic rise_flag_r, rise_flag_nxt;
	logic rdone_r, rdone_nxt;
	logic wdone_r, wdone_nxt;
	logic wpend_r, wpend_nxt;
	logic irq_flag_r, irq_flag_nxt;
	logic stretch_en_r, stretch_en_nxt;
	logic enable_r, enable_nxt;
	logic hold_r, hold_nxt;
	logic [7:0] rdata_nxt;
	logic sda_oe_n_nxt, scl_oe_n_nxt;
	logic buf_in_ready, buf_out_valid;
	logic [7:0] buf_out_data;
	logic [4:0] status_code;

	// decode of one access against the current register set
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr, input logic strobe,
		input logic set_ok);
		hit = strobe && set_ok && (addr == reg_addr);
	endfunction

	// ****************************************
	// register port decode
	// ****************************************
	// set chosen by select
	assign wr_byte_data = hit(i_sfr_addr, SBI_ADDR_BYTE_DATA, i_sfr_wr, i_byte_select);
	assign rd_byte_data = hit(i_sfr_addr, SBI_ADDR_BYTE_DATA, i_sfr_rd, i_byte_select);
	assign wr_bit_data = hit(i_sfr_addr, SBI_ADDR_BIT_DATA, i_sfr_wr, !i_byte_select);
	assign rd_bit_data = hit(i_sfr_addr, SBI_ADDR_BIT_DATA, i_sfr_rd, !i_byte_select);
	assign wr_bit_int = hit(i_sfr_addr, SBI_ADDR_BIT_INTERRUPT, i_sfr_wr, !i_byte_select);
	assign wr_line_ctl = hit(i_sfr_addr, SBI_ADDR_LINE_CONTROL, i_sfr_wr, !i_byte_select);

	// ****************************************
	// line sampling
	// ****************************************
	// three stages per line; the level moves only once the last two agree
	always_comb
	begin
		sda_sync_nxt = {sda_sync_r[1:0], i_sda_in};
		scl_sync_nxt = {scl_sync_r[1:0], i_scl_in};
		sda_lvl_nxt = sda_lvl_r;
		scl_lvl_nxt = scl_lvl_r;
		if (!enable_r)
		begin
			sda_lvl_nxt = 1'b1;
			scl_lvl_nxt = 1'b1;
		end
		else
		begin
			if (sda_sync_r[1] == sda_sync_r[2])
				sda_lvl_nxt = sda_sync_r[2];
			if (scl_sync_r[1] == scl_sync_r[2])
				scl_lvl_nxt = scl_sync_r[2];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			sda_sync_r <= 3'h7;
			scl_sync_r <= 3'h7;
			sda_lvl_r <= 1'b1;
			scl_lvl_r <= 1'b1;
			sda_prev_r <= 1'b1;
			scl_prev_r <= 1'b1;
		end
		else
		begin
			sda_sync_r <= sda_sync_nxt;
			scl_sync_r <= scl_sync_nxt;
			sda_lvl_r <= sda_lvl_nxt;
			scl_lvl_r <= scl_lvl_nxt;
			sda_prev_r <= sda_lvl_r;
			scl_prev_r <= scl_lvl_r;
		end
	end

	// line events; start and stop are data edges while the clock is high
	assign scl_rise = scl_lvl_r && !scl_prev_r;
	assign scl_fall = !scl_lvl_r && scl_prev_r;
	assign bus_start = !sda_lvl_r && sda_prev_r && scl_lvl_r && scl_prev_r;
	assign bus_stop = sda_lvl_r && !sda_prev_r && scl_lvl_r && scl_prev_r;

	// ****************************************
	// byte capture
	// ****************************************
	// a full buffer keeps the machine in push, which stretches the clock when stretch is enabled
	always_comb
	begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		byte_data_nxt = byte_data_r;
		// software loads the byte that a data read returns while no received byte waits
		if (wr_byte_data)
			byte_data_nxt = i_sfr_wdata;
		if (bus_stop || !enable_r)
			state_nxt = SBI_ST_IDLE;
		else if (bus_start)
		begin
			state_nxt = SBI_ST_SHIFT;
			bit_cnt_nxt = SBI_BITCNT_RST;
		end
		else
		begin
			unique case (state_r)
				SBI_ST_IDLE:
					state_nxt = SBI_ST_IDLE;
				SBI_ST_SHIFT:
					if (scl_rise)
					begin
						// the ninth clock is the acknowledge and is not stored
						if (bit_cnt_r == SBI_BITS_WITH_ACK - 4'h1)
							bit_cnt_nxt = SBI_BITCNT_RST;
						else
						begin
							shift_nxt = {shift_r[6:0], sda_lvl_r};
							bit_cnt_nxt = bit_cnt_r + 4'h1;
							if (bit_cnt_r == SBI_BITS_PER_BYTE - 4'h1 && i_byte_select)
								state_nxt = SBI_ST_PUSH;
						end
					end
				SBI_ST_PUSH:
					if (buf_in_ready)
						state_nxt = SBI_ST_SHIFT;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			state_r <= SBI_ST_IDLE;
			shift_r <= SBI_BYTE_DATA_RST;
			bit_cnt_r <= SBI_BITCNT_RST;
			byte_data_r <= SBI_BYTE_DATA_RST;
		end
		else
		begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			byte_data_r <= byte_data_nxt;
		end
	end

	// received bytes wait here until software reads the data register
	sbi_buf2 #(
		.WIDTH(8)
	) u_rx_buf (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_in_valid(state_r == SBI_ST_PUSH),
		.i_in_data(shift_r),
		.o_in_ready(buf_in_ready),
		.o_out_valid(buf_out_valid),
		.o_out_data(buf_out_data),
		.i_out_ready(rd_byte_data)
	);

	always_comb
	begin
		if (state_r == SBI_ST_PUSH && !buf_in_ready)
			status_code = SBI_STAT_STALL;
		else if (buf_out_valid)
			status_code = SBI_STAT_READY;
		else if (busy_r)
			status_code = SBI_STAT_BUSY;
		else
			status_code = SBI_STAT_IDLE;
	end

	// ****************************************
	// bit-oriented flags and controls
	// ****************************************
	// for the rise, read done, write done and interrupt flags the hardware set is applied last so it wins over a clear
	always_comb
	begin
		busy_nxt = busy_r;
		data_out_nxt = data_out_r;
		clock_out_nxt = clock_out_r;
		rise_flag_nxt = rise_flag_r;
		rdone_nxt = rdone_r;
		wdone_nxt = wdone_r;
		wpend_nxt = wpend_r;
		irq_flag_nxt = irq_flag_r;
		stretch_en_nxt = stretch_en_r;
		enable_nxt = enable_r;
		hold_nxt = hold_r;
		if (bus_stop || !enable_r)
			busy_nxt = 1'b0;
		else if (bus_start)
			busy_nxt = 1'b1;
		if (wr_bit_data)
		begin
			data_out_nxt = i_sfr_wdata[SBI_BIT_DATA_POS];
			wdone_nxt = 1'b0;
			wpend_nxt = 1'b1;
			hold_nxt = 1'b0;
		end
		if (wr_line_ctl)
		begin
			data_out_nxt = i_sfr_wdata[SBI_LC_DATA_POS];
			clock_out_nxt = i_sfr_wdata[SBI_LC_CLOCK_POS];
			rise_flag_nxt = i_sfr_wdata[SBI_LC_RISE_POS];
			stretch_en_nxt = i_sfr_wdata[SBI_LC_STRETCH_POS];
			enable_nxt = i_sfr_wdata[SBI_LC_ENABLE_POS];
			hold_nxt = 1'b0;
		end
		if (wr_bit_int)
			irq_flag_nxt = i_sfr_wdata[SBI_INT_FLAG_POS];
		// reading the data bit takes the finished read
		if (rd_bit_data)
			rdone_nxt = 1'b0;
		if (scl_rise)
		begin
			rise_flag_nxt = 1'b1;
			rdone_nxt = 1'b1;
			irq_flag_nxt = 1'b1;
		end
		if (scl_fall && wpend_r)
		begin
			wdone_nxt = 1'b1;
			wpend_nxt = wr_bit_data; // a bit written in this same cycle stays pending
			irq_flag_nxt = 1'b1;
		end
		// bit mode holds clock after fall
		if (scl_fall && stretch_en_r && !i_byte_select)
			hold_nxt = 1'b1;
		if (!stretch_en_nxt || i_byte_select)
			hold_nxt = 1'b0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			busy_r <= 1'b0;
			data_out_r <= SBI_LINE_OUT_RST;
			clock_out_r <= SBI_LINE_OUT_RST;
			rise_flag_r <= 1'b0;
			rdone_r <= 1'b0;
			wdone_r <= 1'b0;
			wpend_r <= 1'b0;
			irq_flag_r <= 1'b0;
			stretch_en_r <= SBI_STRETCH_RST;
			enable_r <= SBI_ENABLE_RST;
			hold_r <= 1'b0;
		end
		else
		begin
			busy_r <= busy_nxt;
			data_out_r <= data_out_nxt;
			clock_out_r <= clock_out_nxt;
			rise_flag_r <= rise_flag_nxt;
			rdone_r <= rdone_nxt;
			wdone_r <= wdone_nxt;
			wpend_r <= wpend_nxt;
			irq_flag_r <= irq_flag_nxt;
			stretch_en_r <= stretch_en_nxt;
			enable_r <= enable_nxt;
			hold_r <= hold_nxt;
		end
	end

	// ****************************************
	// read data and pin drive
	// ****************************************
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (i_sfr_rd)
		begin
			if (rd_byte_data)
				// received byte, else the loaded one
				rdata_nxt = buf_out_valid ? buf_out_data : byte_data_r;
			else if (hit(i_sfr_addr, SBI_ADDR_BYTE_STATUS, i_sfr_rd, i_byte_select))
				rdata_nxt = {3'h0, status_code};
			else if (rd_bit_data)
				rdata_nxt[SBI_BIT_DATA_POS] = sda_lvl_r;
			else if (hit(i_sfr_addr, SBI_ADDR_BIT_INTERRUPT, i_sfr_rd, !i_byte_select))
				rdata_nxt[SBI_INT_FLAG_POS] = irq_flag_r;
			else if (hit(i_sfr_addr, SBI_ADDR_LINE_CONTROL, i_sfr_rd, !i_byte_select))
			begin
				rdata_nxt[SBI_LC_DATA_POS] = sda_lvl_r;
				rdata_nxt[SBI_LC_CLOCK_POS] = scl_lvl_r;
				rdata_nxt[SBI_LC_RISE_POS] = rise_flag_r;
				rdata_nxt[SBI_LC_BUSY_POS] = busy_r;
				rdata_nxt[SBI_LC_RDONE_POS] = rdone_r;
				rdata_nxt[SBI_LC_WDONE_POS] = wdone_r;
				rdata_nxt[SBI_LC_STRETCH_POS] = stretch_en_r;
				rdata_nxt[SBI_LC_ENABLE_POS] = enable_r;
			end
		end
		sda_oe_n_nxt = !(enable_r && !data_out_r);
		// stretch on hold or full buffer
		scl_oe_n_nxt = !(enable_r && (!clock_out_r || hold_r ||
			(stretch_en_r && state_r == SBI_ST_PUSH && !buf_in_ready)));
	end

	// outputs leave from flip-flops; the driven level is always low
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_sfr_rdata <= 8'h00;
			o_sda_out <= 1'b0;
			o_scl_out <= 1'b0;
			o_sda_oe_n <= 1'b1;
			o_scl_oe_n <= 1'b1;
		end
		else
		begin
			o_sfr_rdata <= rdata_nxt;
			o_sda_out <= 1'b0;
			o_scl_out <= 1'b0;
			o_sda_oe_n <= sda_oe_n_nxt;
			o_scl_oe_n <= scl_oe_n_nxt;
		end
	end

endmodule

// ### tb.sv
// testbench for the serial register block and a remote bus master
`timescale 1ns/1ps
module tb;
	import sbi_pkg::*;
	localparam logic [7:0] A_LC = SBI_ADDR_LINE_CONTROL;
	localparam logic [7:0] A_D = SBI_ADDR_BIT_DATA;
	localparam logic [7:0] A_S = SBI_ADDR_BYTE_STATUS;
	logic i_mclk;
	logic i_srst;
	logic sel;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic sda_out, sda_oe_n, scl_out, scl_oe_n, m_sda, m_scl;
	int lost;
	int num_errors = 0;
	int n_checks = 0;
	// wired-and with pull-ups
	wire sda = (sda_oe_n | sda_out) & m_sda;
	wire scl = (scl_oe_n | scl_out) & m_scl;
	sbi_serial_regs DUT (.i_mclk, .i_srst, .i_byte_select(sel), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_sda_in(sda), .o_sda_out(sda_out),
		.o_sda_oe_n(sda_oe_n), .i_scl_in(scl), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n));
	sbi_bus_model u_bus (.i_sda(sda), .i_scl(scl), .o_sda_rel(m_sda), .o_scl_rel(m_scl), .o_lost(lost));
	initial
	begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge i_mclk);
		wr = 1'b0;
	endtask
	// read data stands for the one cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_mclk);
		rd = 1'b1;
		addr = a;
		@(negedge i_mclk);
		rd = 1'b0;
		d = rdata;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(what, d, exp);
	endtask
	// line inputs pass a synchroniser, so give them time
	task automatic settle();
		repeat (8) @(negedge i_mclk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_status(input logic [7:0] exp);
		logic [7:0] d;
		int n;
		n = 0;
		d = 8'h00;
		while (d !== exp && n < 3000)
		begin
			rd_reg(A_S, d);
			n++;
		end
		if (d !== exp)
		begin
			chk("status wait", d, exp);
			stop_test();
		end
	endtask
	initial
	begin
		i_srst = 1'b1;
		sel = 1'b0;
		addr = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
		repeat (5) @(negedge i_mclk);
		i_srst = 1'b0;
		rchk("lc reset", A_LC, 8'hC0);
		rchk("unmapped", 8'h00, 8'h00);
		chk("oe reset", {6'h0, sda_oe_n, scl_oe_n}, 8'h03);
		// pull both lines, then let go: the clock rise sets the flags
		wr_reg(A_LC, 8'h01);
		settle();
		chk("oe low", {6'h0, sda_oe_n, scl_oe_n}, 8'h00);
		rchk("lc low", A_LC, 8'h01);
		wr_reg(A_LC, 8'hC1);
		settle();
		rchk("lc rise", A_LC, 8'hE9);
		rchk("int flag", SBI_ADDR_BIT_INTERRUPT, 8'h01);
		wr_reg(SBI_ADDR_BIT_INTERRUPT, 8'h00);
		rchk("int clear", SBI_ADDR_BIT_INTERRUPT, 8'h00);
		wr_reg(A_LC, 8'hE1);
		rchk("rise set", A_LC, 8'hE9);
		wr_reg(A_LC, 8'hC1);
		rchk("rise clr", A_LC, 8'hC9);
		rchk("bit data", A_D, 8'h01);
		rchk("rdone clr", A_LC, 8'hC1);
		$display("test line control done");
		// data low with clock high is a start, high again is a stop
		wr_reg(A_D, 8'h00);
		settle();
		chk("bit drive", {7'h0, sda_oe_n}, 8'h00);
		u_bus.pulse();
		settle();
		rchk("lc busy", A_LC, 8'h7D);
		wr_reg(A_D, 8'h01);
		settle();
		rchk("lc stop", A_LC, 8'hE9);
		// stretch: the device holds the clock after the master's fall
		wr_reg(A_LC, 8'hC3);
		fork
			u_bus.pulse();
			begin
				repeat (40) @(negedge i_mclk);
				chk("stretch", {7'h0, scl_oe_n}, 8'h00);
				// the master's low phase is shorter than sync plus hold delay, so a short high sets the rise flag
				rchk("lc stretch", A_LC, 8'hAF);
				wr_reg(A_LC, 8'hC3);
			end
		join
		settle();
		$display("test bit mode done");
		// byte set, with stretch on so a full buffer holds the clock
		@(negedge i_mclk);
		sel = 1'b1;
		rchk("status idle", A_S, SBI_STAT_IDLE);
		wr_reg(A_S, 8'h00);
		rchk("status ro", A_S, SBI_STAT_IDLE);
		rchk("lc hidden", A_LC, 8'h00);
		wr_reg(SBI_ADDR_BYTE_DATA, 8'hA5);
		rchk("byte wr", A_D, 8'hA5);
		fork
			begin
				u_bus.start();
				u_bus.send(8'h96);
				u_bus.send(8'h3C);
				u_bus.send(8'h81);
				u_bus.stop();
			end
			begin
				wait_status(SBI_STAT_STALL);
				settle();
				chk("full hold", {7'h0, scl_oe_n}, 8'h00);
				rchk("byte 0", A_D, 8'h96);
			end
		join
		settle();
		rchk("status rdy", A_S, SBI_STAT_READY);
		rchk("byte 1", A_D, 8'h3C);
		rchk("byte 2", A_D, 8'h81);
		rchk("byte none", A_D, 8'hA5);
		rchk("status end", A_S, SBI_STAT_IDLE);
		chk("waits lost", lost[7:0], 8'h00);
		$display("test byte mode done");
		// switching off lets both lines float
		@(negedge i_mclk);
		sel = 1'b0;
		wr_reg(A_LC, 8'h00);
		settle();
		chk("oe off", {6'h0, sda_oe_n, scl_oe_n}, 8'h03);
		$display("test disable done");
		stop_test();
	end
endmodule
